// ---- src/plt_pkg.sv ----
`default_nettype none
package plt_pkg;
   // -------------------------------------------------------------
   // Table geometry and codes
   // -------------------------------------------------------------
   localparam int          NPTS       = 11;
   localparam int          DW         = 16;
   localparam logic [1:0]  MODE_DATA  = 2'h0;
   localparam logic [1:0]  MODE_TIME  = 2'h1;
   localparam logic [1:0]  MODE_THR   = 2'h2;
   localparam logic [1:0]  SHP_IGNORE = 2'h0;
   localparam logic [1:0]  SHP_LINEAR = 2'h1;
   localparam logic [1:0]  SHP_STEP   = 2'h2;
   localparam logic [1:0]  KIND_NONE  = 2'h0;
   localparam logic [1:0]  KIND_INPUT = 2'h1;
   localparam logic [1:0]  KIND_MATH  = 2'h2;
   localparam logic [15:0] XSPAN_MIN  = 16'h0000;
   localparam logic [15:0] XSPAN_MAX  = 16'h2710;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int          CLK_NS     = 25;
   localparam int          MS_NS      = 1000000;
   localparam int          MS_CYC     = MS_NS / CLK_NS;
   // -------------------------------------------------------------
   // Register map: addr[7:4] bank, addr[3:0] index
   // -------------------------------------------------------------
   localparam logic [3:0]  BANK_CTL   = 4'h0;
   localparam logic [3:0]  BANK_X     = 4'h1;
   localparam logic [3:0]  BANK_Y     = 4'h2;
   localparam logic [3:0]  BANK_SHP   = 4'h3;
   localparam logic [3:0]  R_CTRL     = 4'h0;
   localparam logic [3:0]  R_THR      = 4'h1;
   localparam logic [3:0]  R_NEUT     = 4'h2;
   localparam logic [3:0]  R_DISOUT   = 4'h3;
   localparam logic [3:0]  R_STAT     = 4'h4;
   localparam logic [3:0]  R_TIME     = 4'h5;
   localparam logic [3:0]  R_OUT      = 4'h6;
   localparam logic [3:0]  R_OMIN     = 4'h7;
   localparam logic [3:0]  R_OMAX     = 4'h8;
   // CTRL fields
   localparam int          F_MODE     = 0;
   localparam int          F_AUTO     = 2;
   localparam int          F_KIND     = 4;
   localparam int          F_IDX      = 8;
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] WORD_RST   = 16'h0000;
   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } plt_req_t;
   typedef enum logic [1:0] {
      GATE_ON  = 2'b01,
      GATE_OFF = 2'b10
   } plt_gate_t;
endpackage
`default_nettype wire

// ---- src/plt_table.sv ----
// What this block does
// - Eleven breakpoints, ten segments, X and Y.
// - Mode 0 data, 1 time, 2 threshold.
// - Data mode compares raw selected source value.
// - Time mode: X in ms, source enables.
// - Threshold mode outputs disabled value when off.
// - Off after threshold, on again at neutral.
// - Shape code 0 ignore, 1 ramp, 2 step.
// - Ramp interpolates between neighbouring Y values.
// - Step gives current point Y exactly.
// - Point zero shape always step.
// - Ignore drops point and all above.
// - Autocycle restarts time while enabled.
// - Input/math sources clamp X to range.
// - Other sources clamp X to 0..10000.
// - X non-decreasing; edit highest index first.
// - Y values are unconstrained.
// - Output range is min/max live Y.
`timescale 1ns/1ps
`default_nettype none
module plt_table
   import plt_pkg::*;
#(
   parameter int NSRC      = 8,
   parameter int MS_CYCLES = MS_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // Register port
   input  wire plt_req_t          req,
   output logic [DW-1:0]          rdata_q,
   // Sources from other blocks, same clock
   input  wire logic [NSRC*DW-1:0] sig_i,
   input  wire logic [NSRC*DW-1:0] rng_min_i,
   input  wire logic [NSRC*DW-1:0] rng_max_i,
   // Table results
   output logic signed [DW-1:0]   out_q,
   output logic signed [DW-1:0]   out_min_q,
   output logic signed [DW-1:0]   out_max_q,
   output logic                   disabled_q
);
   localparam int IW = $clog2(NSRC);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [DW-1:0] umax(input logic [DW-1:0] a, input logic [DW-1:0] b);
      umax = (a > b) ? a : b;
   endfunction
   function automatic logic [DW-1:0] umin(input logic [DW-1:0] a, input logic [DW-1:0] b);
      umin = (a < b) ? a : b;
   endfunction

   // -------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------
   logic [DW-1:0]        ctrl_q, thr_q, neut_q, dis_out_q;
   logic [DW-1:0]        x_q [NPTS];
   logic signed [DW-1:0] y_q [NPTS];
   logic [1:0]           shp_q [NPTS];
   plt_gate_t            gate_q, gate_d;
   logic [31:0]          pre_q;
   logic [DW-1:0]        tms_q;
   logic                 en_q;
   logic signed [DW-1:0] out_d;

   wire [1:0]    mode   = ctrl_q[F_MODE +: 2];
   wire          auto   = ctrl_q[F_AUTO];
   wire [1:0]    kind   = ctrl_q[F_KIND +: 2];
   wire [IW-1:0] sidx   = ctrl_q[F_IDX +: IW];
   wire [3:0]    bank   = req.addr[7:4];
   wire [3:0]    ridx   = req.addr[3:0];
   wire          pt_ok  = (ridx < 4'(NPTS));
   wire          wr_ctl = req.wr && (bank == BANK_CTL);
   wire          wr_x   = req.wr && (bank == BANK_X) && pt_ok;
   wire          wr_y   = req.wr && (bank == BANK_Y) && pt_ok;
   wire          wr_s   = req.wr && (bank == BANK_SHP) && pt_ok && (ridx != 4'h0);

   // Selected source and its X span
   wire [DW-1:0] raw    = sig_i[sidx*DW +: DW];
   wire          ranged = (kind == KIND_INPUT) || (kind == KIND_MATH);
   wire [DW-1:0] xmin   = ranged ? rng_min_i[sidx*DW +: DW] : XSPAN_MIN;
   wire [DW-1:0] xmax   = ranged ? rng_max_i[sidx*DW +: DW] : XSPAN_MAX;
   wire          en_now = (raw != WORD_RST);

   // -------------------------------------------------------------
   // Live points and effective X axis
   // -------------------------------------------------------------
   // X is clamped live, so a range change re-derives it at once; the
   // running max keeps the axis rising even mid-way through an edit.
   logic [NPTS-1:0] live;
   logic [DW-1:0]   xe [NPTS];
   logic [3:0]      last;
   logic signed [DW-1:0] ymin, ymax;
   always_comb begin
      live[0] = 1'b1;
      xe[0]   = umin(umax(x_q[0], xmin), xmax);
      last    = 4'h0;
      ymin    = y_q[0];
      ymax    = y_q[0];
      for (int i = 1; i < NPTS; i++) begin
         live[i] = live[i-1] && (shp_q[i] != SHP_IGNORE);
         xe[i]   = umax(umin(umax(x_q[i], xmin), xmax), xe[i-1]);
         if (live[i]) begin
            last = 4'(i);
            if (y_q[i] < ymin) ymin = y_q[i];
            if (y_q[i] > ymax) ymax = y_q[i];
         end
      end
   end
   wire [DW-1:0] xlast = xe[last];

   // -------------------------------------------------------------
   // Segment search and interpolation
   // -------------------------------------------------------------
   wire [DW-1:0] xin = (mode == MODE_TIME) ? tms_q : raw;
   logic [3:0]           seg;
   logic signed [DW-1:0] tab;
   logic signed [DW:0]   dy;
   logic [DW-1:0]        dx, px;
   logic signed [2*DW+1:0] prod;
   always_comb begin
      seg = 4'h0;
      for (int i = 1; i < NPTS; i++)
         if (live[i] && (xin > xe[i-1])) seg = 4'(i);
      dy   = (DW+1)'(y_q[seg]) - (DW+1)'(y_q[seg == 4'h0 ? 4'h0 : seg - 4'h1]);
      dx   = xe[seg] - xe[seg == 4'h0 ? 4'h0 : seg - 4'h1];
      px   = xin - xe[seg == 4'h0 ? 4'h0 : seg - 4'h1];
      prod = (2*DW+2)'(dy) * $signed({2'b00, px});
      if (seg == 4'h0 || xin >= xe[seg] || dx == WORD_RST)
         tab = y_q[seg];
      else if (shp_q[seg] == SHP_LINEAR)
         tab = DW'(y_q[seg-4'h1] + DW'(prod / $signed({2'b00, dx})));
      else
         tab = y_q[seg];
   end

   // -------------------------------------------------------------
   // Threshold gate
   // -------------------------------------------------------------
   // Once tripped the gate stays off until the stick is back at neutral or the mode is no longer threshold.
   always_comb begin
      gate_d = gate_q;
      unique case (gate_q)
         GATE_ON:  if (mode == MODE_THR && raw > thr_q) gate_d = GATE_OFF;
         GATE_OFF: if (mode != MODE_THR || raw <= neut_q) gate_d = GATE_ON;
      endcase
   end

   // Output select: a disabled gate or idle timer shows the disabled value
   always_comb begin
      if (mode == MODE_THR && gate_q == GATE_OFF)
         out_d = dis_out_q;
      else if (mode == MODE_TIME && !en_now)
         out_d = dis_out_q;
      else
         out_d = tab;
   end

   // -------------------------------------------------------------
   // Millisecond timer
   // -------------------------------------------------------------
   wire ms_tick = (pre_q == 32'(MS_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (srst || mode != MODE_TIME || !en_now || !en_q) begin
         pre_q <= '0;
         tms_q <= '0;
      end else begin
         pre_q <= ms_tick ? '0 : pre_q + 32'h1;
         if (ms_tick && tms_q >= xlast)
            tms_q <= auto ? '0 : tms_q;
         else if (ms_tick)
            tms_q <= tms_q + 16'h1;
      end
   end

   // -------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q    <= CTRL_RST;
         thr_q     <= WORD_RST;
         neut_q    <= WORD_RST;
         dis_out_q <= WORD_RST;
      end else if (wr_ctl) begin
         if (ridx == R_CTRL)   ctrl_q    <= req.wdata;
         if (ridx == R_THR)    thr_q     <= req.wdata;
         if (ridx == R_NEUT)   neut_q    <= req.wdata;
         if (ridx == R_DISOUT) dis_out_q <= req.wdata;
      end
   end

   // Breakpoint arrays; point zero keeps its step shape
   always_ff @(posedge clk) begin
      for (int i = 0; i < NPTS; i++) begin
         if (srst) begin
            x_q[i]   <= WORD_RST;
            y_q[i]   <= WORD_RST;
            shp_q[i] <= (i == 0) ? SHP_STEP : SHP_IGNORE;
         end else begin
            if (wr_x && ridx == 4'(i)) x_q[i]   <= req.wdata;
            if (wr_y && ridx == 4'(i)) y_q[i]   <= req.wdata;
            if (wr_s && ridx == 4'(i)) shp_q[i] <= req.wdata[1:0];
         end
      end
   end

   // -------------------------------------------------------------
   // Read mux
   // -------------------------------------------------------------
   wire [DW-1:0] stat = {8'h00, 4'(last), 2'b00, en_now, gate_q == GATE_OFF};
   wire [3:0]    pi   = pt_ok ? ridx : 4'h0;
   logic [DW-1:0] rd_mux;
   always_comb begin
      rd_mux = WORD_RST;
      unique case (bank)
         BANK_CTL: begin
            unique case (ridx)
               R_CTRL:   rd_mux = ctrl_q;
               R_THR:    rd_mux = thr_q;
               R_NEUT:   rd_mux = neut_q;
               R_DISOUT: rd_mux = dis_out_q;
               R_STAT:   rd_mux = stat;
               R_TIME:   rd_mux = tms_q;
               R_OUT:    rd_mux = out_q;
               R_OMIN:   rd_mux = out_min_q;
               R_OMAX:   rd_mux = out_max_q;
               default:  rd_mux = WORD_RST;
            endcase
         end
         BANK_X:   rd_mux = pt_ok ? xe[pi] : WORD_RST;
         BANK_Y:   rd_mux = pt_ok ? y_q[pi] : WORD_RST;
         BANK_SHP: rd_mux = pt_ok ? {14'h0000, shp_q[pi]} : WORD_RST;
         default:  rd_mux = WORD_RST;
      endcase
   end

   // Outputs and state, all registered
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q    <= WORD_RST;
         out_q      <= WORD_RST;
         out_min_q  <= WORD_RST;
         out_max_q  <= WORD_RST;
         disabled_q <= 1'b0;
         gate_q     <= GATE_ON;
         en_q       <= 1'b0;
      end else begin
         rdata_q    <= req.rd ? rd_mux : WORD_RST;
         out_q      <= out_d;
         out_min_q  <= ymin;
         out_max_q  <= ymax;
         disabled_q <= (gate_d == GATE_OFF);
         gate_q     <= gate_d;
         en_q       <= en_now;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic mono_ok;
   always_comb begin
      mono_ok = 1'b1;
      for (int i = 1; i < NPTS; i++) if (xe[i] < xe[i-1]) mono_ok = 1'b0;
   end

   property p_shape0;
      req.rd && bank == BANK_SHP && ridx == 4'h0 |=> rdata_q == 16'(SHP_STEP);
   endproperty
   a_shape0: assert property (p_shape0) else $error("point zero not step");
   property p_trip;
      mode == MODE_THR && gate_q == GATE_ON && raw > thr_q |=> disabled_q && gate_q == GATE_OFF;
   endproperty
   a_trip: assert property (p_trip) else $error("gate did not trip");
   property p_hold;
      gate_q == GATE_OFF && mode == MODE_THR && raw > neut_q |=> gate_q == GATE_OFF;
   endproperty
   a_hold: assert property (p_hold) else $error("gate released early");
   property p_disout;
      mode == MODE_THR && gate_q == GATE_OFF |=> out_q == $past(dis_out_q);
   endproperty
   a_disout: assert property (p_disout) else $error("disabled value not shown");
   property p_tzero;
      mode == MODE_TIME && !en_now |=> (tms_q == 16'h0000) [*2];
   endproperty
   a_tzero: assert property (p_tzero) else $error("timer not held at zero");
   property p_range;
      ##1 out_min_q <= $past(y_q[0]) && $past(y_q[0]) <= out_max_q;
   endproperty
   a_range: assert property (p_range) else $error("output range inverted");
   property p_mono;
      mono_ok;
   endproperty
   a_mono: assert property (p_mono) else $error("x axis not rising");
   property p_span;
      !ranged |-> xlast <= XSPAN_MAX;
   endproperty
   a_span: assert property (p_span) else $error("x beyond default span");
   property p_step;
      mode == MODE_DATA && seg != 4'h0 && shp_q[seg] == SHP_STEP |=> out_q == $past(y_q[seg]);
   endproperty
   a_step: assert property (p_step) else $error("step value wrong");
endmodule
`default_nettype wire

// ---- verification/plt_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module plt_src_model
   import plt_pkg::*;
#(
   parameter int          NSRC = 8,
   parameter logic [15:0] RMIN = 16'h0000,
   parameter logic [15:0] RMAX = 16'h01F4
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // Load request from the bench
   input  wire logic              ld,
   input  wire logic [2:0]        ld_idx,
   input  wire logic [DW-1:0]     ld_val,
   // Signals seen by the table
   output logic [NSRC*DW-1:0]     sig_o,
   output logic [NSRC*DW-1:0]     rng_min_o,
   output logic [NSRC*DW-1:0]     rng_max_o
);
   // Ranges are fixed; re-ranging at run time is not modelled
   assign rng_min_o = {NSRC{RMIN}};
   assign rng_max_o = {NSRC{RMAX}};
   // Each source holds its last value, as a block output does between updates
   always_ff @(posedge clk) begin
      if (srst) begin
         sig_o <= '0;
      end else if (ld) begin
         sig_o[ld_idx*DW +: DW] <= ld_val;
      end
   end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
   import plt_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int            MSC = 4;
   logic                     clk;
   logic                     srst;
   plt_req_t                 req;
   logic [DW-1:0]            rdata_q;
   wire logic [8*DW-1:0]     sig;
   wire logic [8*DW-1:0]     rmin;
   wire logic [8*DW-1:0]     rmax;
   logic signed [DW-1:0]     out_q;
   logic signed [DW-1:0]     omin;
   logic signed [DW-1:0]     omax;
   logic                     dis;
   logic                     ld;
   logic [2:0]               ld_idx;
   logic [DW-1:0]            ld_val;
   logic [15:0]              rv;
   int                       error_cnt;
   int                       total_checks;
   int                       cyc;

   plt_table #(.NSRC(8), .MS_CYCLES(MSC)) uut (.clk(clk), .srst(srst), .req(req),
      .rdata_q(rdata_q), .sig_i(sig), .rng_min_i(rmin), .rng_max_i(rmax), .out_q(out_q),
      .out_min_q(omin), .out_max_q(omax), .disabled_q(dis));
   plt_src_model #(.NSRC(8)) u_src (.clk(clk), .srst(srst), .ld(ld), .ld_idx(ld_idx),
      .ld_val(ld_val), .sig_o(sig), .rng_min_o(rmin), .rng_max_o(rmax));

   // Free-running clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic wrap_up();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      req <= {1'b0, 1'b1, a, 16'h0000};
      @(posedge clk);
      req <= '0;
      #1 d = rdata_q;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   // Source plus one table edge; a few spare cycles hide nothing that matters
   task automatic src(input logic [2:0] i, input logic [15:0] v);
      @(posedge clk);
      ld <= 1'b1;
      ld_idx <= i;
      ld_val <= v;
      @(posedge clk);
      ld <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rchk(8'h00, 16'h0000);
      rchk(8'h30, 16'h0002);
      rchk(8'h31, 16'h0000);
      wr(8'h30, 16'h0001);
      rchk(8'h30, 16'h0002);
      rchk(8'h9F, 16'h0000);
      rchk(8'h3B, 16'h0000);
      chk(out_q, 16'h0000);
   endtask
   task automatic t_data();
      wr(8'h12, 16'h012C);
      wr(8'h11, 16'h00C8);
      wr(8'h10, 16'h0064);
      wr(8'h20, 16'h0032);
      wr(8'h21, 16'hFF9C);
      wr(8'h22, 16'h0190);
      wr(8'h23, 16'h2328);
      wr(8'h31, 16'h0001);
      wr(8'h32, 16'h0002);
      wr(8'h34, 16'h0001);
      wr(8'h00, 16'h0300);
      src(3'h0, 16'h0032);
      src(3'h3, 16'h0096);
      chk(out_q, 16'hFFE7);
      chk(omin, 16'hFF9C);
      chk(omax, 16'h0190);
      src(3'h3, 16'h00C8);
      chk(out_q, 16'hFF9C);
      src(3'h3, 16'h00FA);
      chk(out_q, 16'h0190);
      src(3'h3, 16'h0032);
      chk(out_q, 16'h0032);
      src(3'h3, 16'h03E8);
      chk(out_q, 16'h0190);
   endtask
   task automatic t_clamp();
      wr(8'h1A, 16'hFFFF);
      rchk(8'h1A, 16'h2710);
      wr(8'h11, 16'h0050);
      rchk(8'h11, 16'h0064);
      wr(8'h11, 16'h00C8);
      wr(8'h00, 16'h0310);
      rchk(8'h1A, 16'h01F4);
      wr(8'h00, 16'h0320);
      rchk(8'h1A, 16'h01F4);
      wr(8'h00, 16'h0330);
      rchk(8'h1A, 16'h2710);
      wr(8'h00, 16'h0300);
   endtask
   task automatic t_thr();
      wr(8'h01, 16'h03E8);
      wr(8'h02, 16'h0064);
      wr(8'h03, 16'h1234);
      wr(8'h00, 16'h0302);
      src(3'h3, 16'h00FA);
      chk(out_q, 16'h0190);
      chk_bit(dis, 1'b0);
      src(3'h3, 16'h05DC);
      chk_bit(dis, 1'b1);
      chk(out_q, 16'h1234);
      rchk(8'h04, 16'h0023);
      rchk(8'h06, 16'h1234);
      rchk(8'h07, 16'hFF9C);
      rchk(8'h08, 16'h0190);
      rchk(8'h01, 16'h03E8);
      src(3'h3, 16'h01F4);
      chk_bit(dis, 1'b1);
      src(3'h3, 16'h0064);
      chk_bit(dis, 1'b0);
      chk(out_q, 16'h0032);
      src(3'h3, 16'h03E8);
      chk_bit(dis, 1'b0);
   endtask
   task automatic t_time();
      logic nz;
      logic wrapped;
      nz = 1'b0;
      wrapped = 1'b0;
      src(3'h3, 16'h0000);
      wr(8'h12, 16'h0006);
      wr(8'h11, 16'h0003);
      wr(8'h10, 16'h0000);
      wr(8'h20, 16'h000A);
      wr(8'h21, 16'h0028);
      wr(8'h22, 16'h0046);
      wr(8'h00, 16'h0301);
      src(3'h3, 16'h0000);
      chk(out_q, 16'h1234);
      rchk(8'h05, 16'h0000);
      src(3'h3, 16'h0001);
      repeat (60) @(posedge clk);
      rchk(8'h05, 16'h0006);
      chk(out_q, 16'h0046);
      wr(8'h00, 16'h0305);
      // Timer wraps every few reads, so forty reads must see a restart
      for (int i = 0; i < 40; i++) begin
         rd(8'h05, rv);
         if (rv !== 16'h0000) begin
            nz = 1'b1;
         end else if (nz) begin
            wrapped = 1'b1;
         end
      end
      chk_bit(wrapped, 1'b1);
      src(3'h3, 16'h0000);
      rchk(8'h05, 16'h0000);
      chk(out_q, 16'h1234);
   endtask
   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      req = '0;
      ld = 1'b0;
      ld_idx = 3'h0;
      ld_val = 16'h0000;
      srst = 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_data();
      t_clamp();
      t_thr();
      t_time();
      wrap_up();
   end
endmodule
`default_nettype wire
